// File: hdl/fuse_judge_consts.vh
// Constants for the fuse blow judgement timers
`ifndef FUSE_JUDGE_CONSTS_VH
`define FUSE_JUDGE_CONSTS_VH

// Register addresses
`define ADDR_W 8
`define ADDR_DELAY_CTRL 8'h08
`define ADDR_CUT_CFG 8'h09
`define ADDR_IRQ_STAT 8'h40
`define ADDR_IRQ_MASK 8'h41
`define ADDR_STATUS 8'h42

// Reset values
`define DELAY_CTRL_RST 16'h0000
`define CUT_CFG_RST 16'h000a

// Fuse delay control fields
`define F_V2_HI 15
`define F_V2_LO 12
`define F_V1_HI 11
`define F_V1_LO 9
`define F_VEN 8
`define F_C2_HI 7
`define F_C2_LO 4
`define F_C1_HI 3
`define F_C1_LO 1
`define F_CEN 0

// Cut config fields
`define F_MARG_HI 7
`define F_MARG_LO 6
`define F_OV_DUR 5
`define F_OC_DUR 4
`define F_HOLD_HI 3
`define F_HOLD_LO 0
`define CUT_CFG_MASK 16'h00ff

// Interrupt bits
`define IRQ_W 3
`define IRQ_VQUAL 0
`define IRQ_CQUAL 1
`define IRQ_CUT_DONE 2

// Timing figures
`define TICK_MS 1
`define CLK_HZ 40000000
`define MS_W 20
`define STAGE1_BASE_MS 20'd200
`define STAGE1_STEP_MS 20'd200
`define C2_BASE_MS 20'd500
`define C2_STEP_MS 20'd300
`define HOLD_BASE_MS 20'd30000
`define HOLD_STEP_MS 20'd15000
`define HOLD_MAX_MS 20'd300000
`define V2_D0 20'd1000
`define V2_D1 20'd2000
`define V2_D2 20'd3000
`define V2_D3 20'd4000
`define V2_D4 20'd5000
`define V2_D5 20'd10000
`define V2_D6 20'd20000
`define V2_D7 20'd30000
`define V2_D8 20'd40000
`define V2_D9 20'd50000
`define V2_D10 20'd75000
`define V2_D11 20'd100000
`define V2_D12 20'd120000
`define V2_D13 20'd140000
`define V2_D14 20'd160000
`define V2_D15 20'd180000

// Secondary OV margins in mV
`define MARG_W 8
`define MARG_00 8'd200
`define MARG_01 8'd150
`define MARG_10 8'd100
`define MARG_11 8'd50

// Fuse current thresholds in tenths of mV
`define FUSE_CURRENT_THRESHOLD_W 4
`define FUSE_CURRENT_THRESHOLD_00 4'd10
`define FUSE_CURRENT_THRESHOLD_01 4'd6
`define FUSE_CURRENT_THRESHOLD_10 4'd3
`define FUSE_CURRENT_THRESHOLD_11 4'd1

`endif

// File: hdl/ms_tick_gen.v
// Millisecond tick generator shared by all fuse timers
`timescale 1ns/1ps
module ms_tick_gen #(
    parameter integer CYCLES_PER_TICK = 40000
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire sys_rst_i,
    // Tick
    output reg tick_o
);
    reg [31:0] cnt_ff;

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_ff <= 32'h0000_0000;
            tick_o <= 1'b0;
        end else if (cnt_ff == CYCLES_PER_TICK - 1) begin
            cnt_ff <= 32'h0000_0000;
            tick_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
            tick_o <= 1'b0;
        end
    end
endmodule

// File: hdl/fuse_blow_judge_timers.v
// Fuse blow judgement: two-stage qualification per path and gate hold timer
// How it works
// - Voltage stage-two code maps 1000..180000 ms
// - Stage-one codes: 200 ms plus 200 per step
// - Current stage-two: 500 ms plus 300 per step
// - Voltage judgement runs only when enabled
// - Current judgement runs only when enabled
// - Secondary OV margin selected, 200 to 50 mV
// - Optionally keep OV compare during cut
// - Optionally keep current compare during cut
// - Gate hold 30000 ms plus 15000, top 300000
// - Fuse current threshold fixed at code 00
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "fuse_judge_consts.vh"
module fuse_blow_judge_timers #(
    parameter integer CYCLES_PER_TICK = `CLK_HZ / 1000 * `TICK_MS
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire sys_rst_i,
    // Register port
    input wire [`ADDR_W-1:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    // Comparator results from the analog front end
    input wire cell_ov2_i,
    input wire curr_oc_i,
    // Thresholds and enables handed to the comparators
    output reg [`MARG_W-1:0] secondary_ov_margin_mv_o,
    output reg [`FUSE_CURRENT_THRESHOLD_W-1:0] fuse_current_threshold_o,
    output reg ov_compare_en_o,
    output reg oc_compare_en_o,
    // Fuse gate and interrupt
    output reg fuse_gate_o,
    output reg irq_o
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_STG1 = 4'b0010;
    localparam [3:0] ST_STG2 = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;
    // Only the low byte of the cut config is stored
    localparam [15:0] CUT_CFG_RST16 = `CUT_CFG_RST;

    reg [15:0] delay_ctrl_ff;
    reg [7:0] cut_cfg_ff;
    reg [`IRQ_W-1:0] irq_stat_ff;
    reg [`IRQ_W-1:0] irq_mask_ff;
    reg [3:0] v_st_ff;
    reg [3:0] c_st_ff;
    reg [`MS_W-1:0] v_cnt_ff;
    reg [`MS_W-1:0] c_cnt_ff;
    reg cutting_ff;
    reg [`MS_W-1:0] hold_cnt_ff;
    reg [3:0] nxt_v_st;
    reg [3:0] nxt_c_st;
    reg [`MS_W-1:0] nxt_v_cnt;
    reg [`MS_W-1:0] nxt_c_cnt;
    wire tick;
    wire v_en;
    wire c_en;
    wire v_abn;
    wire c_abn;
    wire fire;
    wire hold_end;
    wire [`IRQ_W-1:0] ev;

    function [`MS_W-1:0] stage1_ms;
        input [2:0] code;
        begin
            stage1_ms = `STAGE1_BASE_MS + `STAGE1_STEP_MS * {17'd0, code};
        end
    endfunction

    function [`MS_W-1:0] v2_ms;
        input [3:0] code;
        begin
            case (code)
                4'h0: v2_ms = `V2_D0;
                4'h1: v2_ms = `V2_D1;
                4'h2: v2_ms = `V2_D2;
                4'h3: v2_ms = `V2_D3;
                4'h4: v2_ms = `V2_D4;
                4'h5: v2_ms = `V2_D5;
                4'h6: v2_ms = `V2_D6;
                4'h7: v2_ms = `V2_D7;
                4'h8: v2_ms = `V2_D8;
                4'h9: v2_ms = `V2_D9;
                4'ha: v2_ms = `V2_D10;
                4'hb: v2_ms = `V2_D11;
                4'hc: v2_ms = `V2_D12;
                4'hd: v2_ms = `V2_D13;
                // Code 1110 undefined; midpoint chosen
                4'he: v2_ms = `V2_D14;
                default: v2_ms = `V2_D15;
            endcase
        end
    endfunction

    function [`MS_W-1:0] c2_ms;
        input [3:0] code;
        begin
            c2_ms = `C2_BASE_MS + `C2_STEP_MS * {16'd0, code};
        end
    endfunction

    function [`MS_W-1:0] hold_ms;
        input [3:0] code;
        begin
            if (code == 4'hf) begin
                hold_ms = `HOLD_MAX_MS;
            end else begin
                hold_ms = `HOLD_BASE_MS + `HOLD_STEP_MS * {16'd0, code};
            end
        end
    endfunction

    ms_tick_gen #(
        .CYCLES_PER_TICK(CYCLES_PER_TICK)
    ) u_tick (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(tick)
    );

    assign v_en = delay_ctrl_ff[`F_VEN];
    assign c_en = delay_ctrl_ff[`F_CEN];
    // During a cut the judgement only sees comparators left enabled
    assign v_abn = v_en & cell_ov2_i & (~cutting_ff | cut_cfg_ff[`F_OV_DUR]);
    assign c_abn = c_en & curr_oc_i & (~cutting_ff | cut_cfg_ff[`F_OC_DUR]);
    assign fire = (v_st_ff == ST_DONE) | (c_st_ff == ST_DONE);
    assign hold_end = cutting_ff & tick & (hold_cnt_ff == {`MS_W{1'b0}});
    assign ev = {hold_end, nxt_c_st == ST_DONE && c_st_ff != ST_DONE,
                 nxt_v_st == ST_DONE && v_st_ff != ST_DONE};

    // Voltage path qualification
    always @* begin
        nxt_v_st = v_st_ff;
        nxt_v_cnt = v_cnt_ff;
        case (v_st_ff)
            ST_IDLE: begin
                if (v_abn) begin
                    nxt_v_st = ST_STG1;
                    nxt_v_cnt = stage1_ms(delay_ctrl_ff[`F_V1_HI:`F_V1_LO]);
                end
            end
            ST_STG1: begin
                if (!v_abn) begin
                    nxt_v_st = ST_IDLE;
                end else if (tick) begin
                    if (v_cnt_ff == {`MS_W{1'b0}}) begin
                        nxt_v_st = ST_STG2;
                        nxt_v_cnt = v2_ms(delay_ctrl_ff[`F_V2_HI:`F_V2_LO]);
                    end else begin
                        nxt_v_cnt = v_cnt_ff - 1'b1;
                    end
                end
            end
            ST_STG2: begin
                if (!v_abn) begin
                    nxt_v_st = ST_IDLE;
                end else if (tick) begin
                    if (v_cnt_ff == {`MS_W{1'b0}}) begin
                        nxt_v_st = ST_DONE;
                    end else begin
                        nxt_v_cnt = v_cnt_ff - 1'b1;
                    end
                end
            end
            ST_DONE: begin
                if (hold_end || !v_en) begin
                    nxt_v_st = ST_IDLE;
                end
            end
            default: nxt_v_st = ST_IDLE;
        endcase
    end

    // Current path qualification
    always @* begin
        nxt_c_st = c_st_ff;
        nxt_c_cnt = c_cnt_ff;
        case (c_st_ff)
            ST_IDLE: begin
                if (c_abn) begin
                    nxt_c_st = ST_STG1;
                    nxt_c_cnt = stage1_ms(delay_ctrl_ff[`F_C1_HI:`F_C1_LO]);
                end
            end
            ST_STG1: begin
                if (!c_abn) begin
                    nxt_c_st = ST_IDLE;
                end else if (tick) begin
                    if (c_cnt_ff == {`MS_W{1'b0}}) begin
                        nxt_c_st = ST_STG2;
                        nxt_c_cnt = c2_ms(delay_ctrl_ff[`F_C2_HI:`F_C2_LO]);
                    end else begin
                        nxt_c_cnt = c_cnt_ff - 1'b1;
                    end
                end
            end
            ST_STG2: begin
                if (!c_abn) begin
                    nxt_c_st = ST_IDLE;
                end else if (tick) begin
                    if (c_cnt_ff == {`MS_W{1'b0}}) begin
                        nxt_c_st = ST_DONE;
                    end else begin
                        nxt_c_cnt = c_cnt_ff - 1'b1;
                    end
                end
            end
            ST_DONE: begin
                if (hold_end || !c_en) begin
                    nxt_c_st = ST_IDLE;
                end
            end
            default: nxt_c_st = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            v_st_ff <= ST_IDLE;
            c_st_ff <= ST_IDLE;
            v_cnt_ff <= {`MS_W{1'b0}};
            c_cnt_ff <= {`MS_W{1'b0}};
        end else begin
            v_st_ff <= nxt_v_st;
            c_st_ff <= nxt_c_st;
            v_cnt_ff <= nxt_v_cnt;
            c_cnt_ff <= nxt_c_cnt;
        end
    end

    // Gate hold timer; a new qualification during a hold does not extend it
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cutting_ff <= 1'b0;
            hold_cnt_ff <= {`MS_W{1'b0}};
            fuse_gate_o <= 1'b0;
        end else if (!cutting_ff) begin
            if (fire) begin
                cutting_ff <= 1'b1;
                fuse_gate_o <= 1'b1;
                hold_cnt_ff <= hold_ms(cut_cfg_ff[`F_HOLD_HI:`F_HOLD_LO]);
            end
        end else if (hold_end) begin
            cutting_ff <= 1'b0;
            fuse_gate_o <= 1'b0;
        end else if (tick) begin
            hold_cnt_ff <= hold_cnt_ff - 1'b1;
        end
    end

    // Comparator setup outputs
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            secondary_ov_margin_mv_o <= `MARG_00;
            fuse_current_threshold_o <= `FUSE_CURRENT_THRESHOLD_00;
            ov_compare_en_o <= 1'b0;
            oc_compare_en_o <= 1'b0;
        end else begin
            case (cut_cfg_ff[`F_MARG_HI:`F_MARG_LO])
                2'b00: secondary_ov_margin_mv_o <= `MARG_00;
                2'b01: secondary_ov_margin_mv_o <= `MARG_01;
                2'b10: secondary_ov_margin_mv_o <= `MARG_10;
                default: secondary_ov_margin_mv_o <= `MARG_11;
            endcase
            // No selector field exists; threshold always driven with code 00
            fuse_current_threshold_o <= `FUSE_CURRENT_THRESHOLD_00;
            ov_compare_en_o <= v_en & (~cutting_ff | cut_cfg_ff[`F_OV_DUR]);
            oc_compare_en_o <= c_en & (~cutting_ff | cut_cfg_ff[`F_OC_DUR]);
        end
    end

    // Register file and interrupt; set wins over write-one-clear
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            delay_ctrl_ff <= `DELAY_CTRL_RST;
            cut_cfg_ff <= CUT_CFG_RST16[7:0];
            irq_stat_ff <= {`IRQ_W{1'b0}};
            irq_mask_ff <= {`IRQ_W{1'b0}};
            rdata_o <= 16'h0000;
            irq_o <= 1'b0;
        end else begin
            if (wr_i && addr_i == `ADDR_DELAY_CTRL) begin
                delay_ctrl_ff <= wdata_i;
            end
            if (wr_i && addr_i == `ADDR_CUT_CFG) begin
                cut_cfg_ff <= wdata_i[7:0];
            end
            if (wr_i && addr_i == `ADDR_IRQ_MASK) begin
                irq_mask_ff <= wdata_i[`IRQ_W-1:0];
            end
            if (wr_i && addr_i == `ADDR_IRQ_STAT) begin
                irq_stat_ff <= (irq_stat_ff & ~wdata_i[`IRQ_W-1:0]) | ev;
            end else begin
                irq_stat_ff <= irq_stat_ff | ev;
            end
            irq_o <= |(irq_stat_ff & irq_mask_ff);
            rdata_o <= 16'h0000;
            if (rd_i) begin
                case (addr_i)
                    `ADDR_DELAY_CTRL: rdata_o <= delay_ctrl_ff;
                    `ADDR_CUT_CFG: rdata_o <= {8'h00, cut_cfg_ff};
                    `ADDR_IRQ_STAT: rdata_o <= {13'h0000, irq_stat_ff};
                    `ADDR_IRQ_MASK: rdata_o <= {13'h0000, irq_mask_ff};
                    `ADDR_STATUS: rdata_o <= {v_st_ff, c_st_ff, 7'h00, cutting_ff};
                    default: rdata_o <= 16'h0000;
                endcase
            end
        end
    end
endmodule

// File: sim/fuse_judge_monitor.sv
// Port checker for the fuse judgement timers
`timescale 1ns/1ps
`include "fuse_judge_consts.vh"
module fuse_judge_monitor #(
    parameter integer CYCLES_PER_TICK = 4
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire sys_rst_i,
    // Register port
    input wire [7:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [15:0] rdata_o,
    // Comparators, gate and interrupt
    input wire cell_ov2_i,
    input wire curr_oc_i,
    input wire [7:0] secondary_ov_margin_mv_o,
    input wire [3:0] fuse_current_threshold_o,
    input wire ov_compare_en_o,
    input wire oc_compare_en_o,
    input wire fuse_gate_o,
    input wire irq_o
);
    reg [15:0] dly_ff;
    reg [7:0] cfg_ff;
    reg [2:0] msk_ff;
    reg [31:0] hold_cnt_ff;
    wire [31:0] hold_ms = (cfg_ff[3:0] == 4'hf) ? 300000 : 30000 + 15000 * cfg_ff[3:0];
    // Hold may end up to one tick early or two ticks late
    wire [31:0] hold_lo = (hold_ms - 1) * CYCLES_PER_TICK;
    wire [31:0] hold_hi = (hold_ms + 2) * CYCLES_PER_TICK;

    function [7:0] marg(input [1:0] s);
        marg = (s == 2'b00) ? `MARG_00 : (s == 2'b01) ? `MARG_01 :
               (s == 2'b10) ? `MARG_10 : `MARG_11;
    endfunction

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dly_ff <= `DELAY_CTRL_RST;
            cfg_ff <= 8'h0a;
            msk_ff <= 3'h0;
            hold_cnt_ff <= 32'h0;
        end else begin
            if (wr_i && addr_i == `ADDR_DELAY_CTRL) dly_ff <= wdata_i;
            if (wr_i && addr_i == `ADDR_CUT_CFG) cfg_ff <= wdata_i[7:0];
            if (wr_i && addr_i == `ADDR_IRQ_MASK) msk_ff <= wdata_i[2:0];
            hold_cnt_ff <= fuse_gate_o ? hold_cnt_ff + 32'h1 : 32'h0;
        end
    end

    chk_rdata_idle_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !rd_i |=> rdata_o == 16'h0000) else $error("read data not zero when idle");
    chk_reset_outputs: assert property (@(posedge sys_clk_i) sys_rst_i |=>
        (!fuse_gate_o && !irq_o && secondary_ov_margin_mv_o == `MARG_00))
        else $error("outputs wrong under reset");
    chk_threshold_fixed: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        fuse_current_threshold_o == `FUSE_CURRENT_THRESHOLD_00) else $error("current threshold wrong");
    chk_margin_map: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (wr_i && addr_i == `ADDR_CUT_CFG) ##1 !(wr_i && addr_i == `ADDR_CUT_CFG) |=>
        secondary_ov_margin_mv_o == marg($past(wdata_i[7:6], 2))) else $error("margin wrong");
    chk_volt_disabled: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (!dly_ff[8] && $past(!dly_ff[8])) |-> !ov_compare_en_o) else $error("ov compare on");
    chk_curr_disabled: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (!dly_ff[0] && $past(!dly_ff[0])) |-> !oc_compare_en_o) else $error("oc compare on");
    chk_cut_ov_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (fuse_gate_o && $past(fuse_gate_o) && !cfg_ff[5] && $past(!cfg_ff[5]))
        |-> !ov_compare_en_o) else $error("ov compare kept during cut");
    chk_hold_time: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $fell(fuse_gate_o) |-> (hold_cnt_ff >= hold_lo && hold_cnt_ff <= hold_hi))
        else $error("gate hold time wrong");
    chk_gate_enabled: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(fuse_gate_o) |-> $past(dly_ff[8] | dly_ff[0], 2)) else $error("gate while off");
    chk_irq_on_cut: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ($rose(fuse_gate_o) && msk_ff[1:0] == 2'b11) |-> ##[0:2] irq_o)
        else $error("no interrupt on cut");

    cover property (@(posedge sys_clk_i) $rose(fuse_gate_o));
    cover property (@(posedge sys_clk_i) $fell(fuse_gate_o));
    cover property (@(posedge sys_clk_i) $rose(irq_o));
endmodule

// File: sim/fuse_model.sv
// Behavioural chemical fuse that opens after enough gate drive
`timescale 1ns/1ps
module fuse_model #(
    parameter integer BLOW_CYCLES = 400
) (
    // Clock
    input wire sys_clk_i,
    // Gate drive
    input wire gate_i,
    // Fuse state
    output reg blown_o
);
    integer heat;
    initial begin
        blown_o = 1'b0;
        heat = 0;
    end
    // Opening is permanent, as with the real part
    always @(posedge sys_clk_i) begin
        heat <= gate_i ? heat + 1 : 0;
        if (gate_i && heat >= BLOW_CYCLES) blown_o <= 1'b1;
    end
endmodule

// File: sim/fuse_blow_judge_timers_tb.sv
// Self-checking bench for the fuse judgement timers
`timescale 1ns/1ps
`include "fuse_judge_consts.vh"
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin \
    err_total = err_total + 1; $display("BAD %0t got %h exp %h", $time, a, b); end end
module fuse_blow_judge_timers_tb;
    localparam integer CPT = 2;
    // One 30000 ms hold is about 60000 cycles; the rest stays well under 10000
    localparam integer LIMIT = 80000;
    reg sys_clk_i = 1'b0;
    reg sys_rst_i = 1'b1;
    reg [7:0] addr_i = 8'h00;
    reg [15:0] wdata_i = 16'h0000;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg cell_ov2_i = 1'b0;
    reg curr_oc_i = 1'b0;
    wire [15:0] rdata_o;
    wire [7:0] margin;
    wire [3:0] thr;
    wire ov_en, oc_en, gate, irq, blown;
    integer err_total = 0, n_tests = 0, cycles = 0, t0, n, i;
    reg [15:0] rv;
    reg [7:0] mexp [0:3];

    fuse_blow_judge_timers #(.CYCLES_PER_TICK(CPT)) DUT (.sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .cell_ov2_i(cell_ov2_i), .curr_oc_i(curr_oc_i),
        .secondary_ov_margin_mv_o(margin), .fuse_current_threshold_o(thr),
        .ov_compare_en_o(ov_en), .oc_compare_en_o(oc_en), .fuse_gate_o(gate), .irq_o(irq));
    fuse_model #(.BLOW_CYCLES(400)) u_fuse (.sys_clk_i(sys_clk_i), .gate_i(gate),
        .blown_o(blown));

    always #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_total = err_total + 1;
            wrap_up;
        end
    end

    task wrap_up;
        begin
            $display("errors %0d checks %0d", err_total, n_tests);
            if (err_total == 0 && n_tests > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge sys_clk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge sys_clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [15:0] d);
        begin
            @(posedge sys_clk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge sys_clk_i);
            rd_i <= 1'b0;
            // Data stands only in the cycle after the strobe
            @(posedge sys_clk_i);
            d = rdata_o;
        end
    endtask
    task ck(input [7:0] a, input [15:0] e);
        begin
            rd(a, rv);
            `CHK(rv, e)
        end
    endtask
    // Polls a 4-bit field until it matches; result in cycles
    task wait_st(input [7:0] a, input integer sh, input [3:0] st, output integer c);
        begin
            c = 0;
            rd(a, rv);
            while (rv[sh+:4] !== st && c < 200000) begin
                rd(a, rv);
                c = c + 3;
            end
        end
    endtask
    task wait_gate(input v);
        begin
            while (gate !== v && cycles < LIMIT) begin
                @(posedge sys_clk_i);
            end
        end
    endtask
    task ck_ms(input integer c, input integer ms);
        `CHK(c >= (ms - 1) * CPT - 4 && c <= (ms + 2) * CPT + 4, 1'b1)
    endtask

    initial begin
        mexp[0] = `MARG_00;
        mexp[1] = `MARG_01;
        mexp[2] = `MARG_10;
        mexp[3] = `MARG_11;
        repeat (6) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        ck(`ADDR_DELAY_CTRL, 16'h0000);
        ck(`ADDR_CUT_CFG, 16'h000a);
        ck(8'h10, 16'h0000);
        `CHK(thr, `FUSE_CURRENT_THRESHOLD_00)
        cell_ov2_i <= 1'b1;
        curr_oc_i <= 1'b1;
        repeat (300 * CPT) @(posedge sys_clk_i);
        ck(`ADDR_STATUS, 16'h1100);
        `CHK({ov_en, oc_en}, 2'b00)
        cell_ov2_i <= 1'b0;
        curr_oc_i <= 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ADDR_CUT_CFG, {8'h00, i[1:0], 6'h00});
            repeat (3) @(posedge sys_clk_i);
            `CHK(margin, mexp[i])
        end
        wr(`ADDR_CUT_CFG, 16'hff00);
        ck(`ADDR_CUT_CFG, 16'h0000);
        wr(`ADDR_IRQ_MASK, 16'h0007);
        wr(`ADDR_DELAY_CTRL, 16'h0100);
        repeat (3) @(posedge sys_clk_i);
        `CHK({ov_en, oc_en}, 2'b10)
        cell_ov2_i <= 1'b1;
        wait_st(`ADDR_STATUS, 12, 4'h2, n);
        repeat (100 * CPT) @(posedge sys_clk_i);
        cell_ov2_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        ck(`ADDR_STATUS, 16'h1100);
        cell_ov2_i <= 1'b1;
        wait_st(`ADDR_STATUS, 12, 4'h2, n);
        wait_st(`ADDR_STATUS, 12, 4'h4, n);
        ck_ms(n, 200);
        t0 = cycles;
        wait_gate(1'b1);
        ck_ms(cycles - t0, 1000);
        t0 = cycles;
        repeat (3) @(posedge sys_clk_i);
        `CHK({irq, ov_en}, 2'b10)
        ck(`ADDR_IRQ_STAT, 16'h0001);
        wr(`ADDR_IRQ_MASK, 16'h0000);
        repeat (2) @(posedge sys_clk_i);
        `CHK(irq, 1'b0)
        wr(`ADDR_IRQ_MASK, 16'h0007);
        wr(`ADDR_IRQ_STAT, 16'h0001);
        repeat (2) @(posedge sys_clk_i);
        `CHK(irq, 1'b0)
        wr(`ADDR_CUT_CFG, 16'h0030);
        repeat (3) @(posedge sys_clk_i);
        `CHK(ov_en, 1'b1)
        cell_ov2_i <= 1'b0;
        wr(`ADDR_DELAY_CTRL, 16'h0113);
        repeat (3) @(posedge sys_clk_i);
        `CHK(oc_en, 1'b1)
        curr_oc_i <= 1'b1;
        wait_st(`ADDR_STATUS, 8, 4'h2, n);
        wait_st(`ADDR_STATUS, 8, 4'h4, n);
        ck_ms(n, 400);
        wait_st(`ADDR_IRQ_STAT, 0, 4'h2, n);
        ck_ms(n, 800);
        curr_oc_i <= 1'b0;
        wait_gate(1'b0);
        ck_ms(cycles - t0, 30000);
        `CHK(blown, 1'b1)
        repeat (4) @(posedge sys_clk_i);
        ck(`ADDR_STATUS, 16'h1100);
        ck(`ADDR_IRQ_STAT, 16'h0006);
        wrap_up;
    end
endmodule

bind fuse_blow_judge_timers fuse_judge_monitor #(.CYCLES_PER_TICK(CYCLES_PER_TICK)) u_mon (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cell_ov2_i(cell_ov2_i),
    .curr_oc_i(curr_oc_i), .secondary_ov_margin_mv_o(secondary_ov_margin_mv_o),
    .fuse_current_threshold_o(fuse_current_threshold_o), .ov_compare_en_o(ov_compare_en_o),
    .oc_compare_en_o(oc_compare_en_o), .fuse_gate_o(fuse_gate_o), .irq_o(irq_o));
